// file: clp_cfg.svh
// Offsets, field positions, reset values and timing figures of the link port register bank.
// Assumes a 10 MHz clock and a byte-offset register address within the adapter space.
`ifndef CLP_CFG_SVH
`define CLP_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define CLP_ADDR_W 20
`define CLP_PORT_OFFSET 20'h4_1004
`define CLP_RXB_OFFSET 20'h4_1008

////////////////////////////////////////////////////////////////////////////////
// Port register fields
`define CLP_STRAP_BIT 31
`define CLP_HUB_OK_BIT 30
`define CLP_ONLINE_BIT 29
`define CLP_ADAPTER_OK_BIT 28
`define CLP_ONLINE_ENTRY_ENABLE_BIT 27
`define CLP_HBSEL_BIT 26
`define CLP_HUB_TYPE_HI 24
`define CLP_HUB_TYPE_LO 22
`define CLP_NODE_ID_HI 21
`define CLP_NODE_ID_LO 16
`define CLP_RXB_HI 31
`define CLP_RXB_LO 27

////////////////////////////////////////////////////////////////////////////////
// Reset and fixed values
`define CLP_HUB_TYPE_RST 3'h0
`define CLP_NODE_ID_RST 6'h00
`define CLP_RXB_RST 5'h00
`define CLP_MASTER_NODE_ID 6'h00
`define CLP_PEER_NODE_ID 6'h01
`define CLP_ZERO32 32'h0000_0000

////////////////////////////////////////////////////////////////////////////////
// Heartbeat timing
`define CLP_CLK_KHZ 10000
`define CLP_HB_LONG_MS 8000
`define CLP_HB_SHORT_MS 2000
// Strap, three link lines, three hub type lines and six id lines
`define CLP_SYNC_W 13

`endif

// file: clp_pkg.sv
// Types shared by the link port register bank.
// Assumes nothing beyond the cfg header.
package clp_pkg;
	typedef enum logic [1:0] {
		ST_OFFLINE,
		ST_LOAD,
		ST_ONLINE
	} clp_state_e;
	typedef logic [5:0] clp_node_id_t;
endpackage

// file: clp_sync.sv
// Two-flop synchroniser for pin levels.
// Assumes multi-bit inputs are quasi-static while they are used.
`timescale 1ns/10ps
module clp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;
endmodule

// file: clp_hb_timer.sv
// Heartbeat watchdog: counts idle cycles while armed, pulses on expiry.
// Assumes kick is a same-clock pulse per transmitted transaction.
`timescale 1ns/10ps
module clp_hb_timer #(
	parameter int W = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Control
	input wire logic run,
	input wire logic kick,
	input wire logic [W-1:0] limit,
	// Event
	output logic expire
);
	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;
	logic expire_r;
	logic expire_nxt;

	always_comb begin
		count_nxt = count_r + W'(1);
		expire_nxt = 1'b0;
		// Restart on any transmit, so one transaction per period keeps the port up
		if (!run || kick) begin
			count_nxt = '0;
		end else if (count_r >= limit - W'(1)) begin
			count_nxt = '0;
			expire_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count_r <= '0;
			expire_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			expire_r <= expire_nxt;
		end
	end

	assign expire = expire_r;
endmodule

// file: clp_port_regs.sv
// Link port control/status and receive window base registers.
// Assumes a same-clock register port; link lines and strap arrive from pins.
//
// Operation
// - Strap state is visible as a read-only status bit.
// - With strap set, this node is node zero and arbitrates the link.
// - Read-only bit shows the hub-ok link signal, zero after reset.
// - Read-only bit shows the link-online signal, zero after reset.
// - Read-only bit shows the adapter-ok link signal, zero after reset.
// - Online state is entered only while the software enable bit is set.
// - Hardware clears the enable bit when entering online state.
// - Select bit picks eight second or two second heartbeat timeout.
// - Hub type field is loaded from the hub during initialisation.
// - Hub type resets to zero and stays zero under virtual hub.
// - A six-bit node identifier is held for link routing.
// - Hub-attached nodes load the node identifier during online sequence.
// - Virtual hub master takes identifier zero, its peer takes one.
// - Five-bit writable receive base selects the inbound host window.
// - Enforced heartbeat takes the port offline after an idle period.
`timescale 1ns/10ps
`include "clp_cfg.svh"
module clp_port_regs #(
	parameter logic [31:0] HB_LONG_CYCLES = 32'(`CLP_HB_LONG_MS * `CLP_CLK_KHZ),
	parameter logic [31:0] HB_SHORT_CYCLES = 32'(`CLP_HB_SHORT_MS * `CLP_CLK_KHZ)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [`CLP_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	// Board strap and link pins
	input wire logic virtual_hub_strap,
	input wire logic hub_ok_in,
	input wire logic link_online_in,
	input wire logic adapter_ok_in,
	input wire logic [2:0] hub_type_in,
	input wire logic [5:0] node_id_in,
	// Local datapath
	input wire logic heartbeat_enforce,
	input wire logic tx_issued,
	// Port state
	output logic port_online,
	output logic link_arbiter,
	output logic [5:0] node_id,
	output logic [5:0] peer_node_id,
	output logic [4:0] receive_window_base
);
	////////////////////////////////////////////////////////////////////////////
	// Address decode

	function automatic logic addr_is(input logic [`CLP_ADDR_W-1:0] a,
		input logic [`CLP_ADDR_W-1:0] off);
		addr_is = (a == off);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	logic [`CLP_SYNC_W-1:0] sync_q;
	logic strap_s;
	logic hub_ok_s;
	logic online_s;
	logic adapter_ok_s;
	logic [2:0] hub_type_s;
	logic [5:0] node_id_s;

	// Id lines are multi-bit; they are only sampled once the link is stable
	clp_sync #(
		.W(`CLP_SYNC_W)
	) u_sync (
		.clk(clk),
		.reset(reset),
		.d({virtual_hub_strap, hub_ok_in, link_online_in, adapter_ok_in,
			hub_type_in, node_id_in}),
		.q(sync_q)
	);

	assign {strap_s, hub_ok_s, online_s, adapter_ok_s, hub_type_s, node_id_s} = sync_q;

	////////////////////////////////////////////////////////////////////////////
	// State and registers

	clp_pkg::clp_state_e state_r;
	clp_pkg::clp_state_e state_nxt;
	logic online_entry_enable_r;
	logic online_entry_enable_nxt;
	logic hb_sel_r;
	logic hb_sel_nxt;
	logic [2:0] hub_type_r;
	logic [2:0] hub_type_nxt;
	clp_pkg::clp_node_id_t node_id_r;
	clp_pkg::clp_node_id_t node_id_nxt;
	logic [4:0] rxb_r;
	logic [4:0] rxb_nxt;
	logic online_r;
	logic online_nxt;
	logic arb_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic rvalid_r;
	logic rd_port_r;
	logic rd_port_nxt;
	logic rd_rxb_r;
	logic rd_rxb_nxt;
	logic partner_ok;
	logic hb_expire;
	logic [31:0] hb_limit;
	logic [31:0] port_word;

	// The partner that must be ready: the hub, or the peer when we arbitrate
	assign partner_ok = arb_r ? adapter_ok_s : (hub_ok_s && online_s);
	assign hb_limit = hb_sel_r ? HB_LONG_CYCLES : HB_SHORT_CYCLES;

	clp_hb_timer #(
		.W(32)
	) u_hb (
		.clk(clk),
		.reset(reset),
		.run(heartbeat_enforce && online_r),
		.kick(tx_issued),
		.limit(hb_limit),
		.expire(hb_expire)
	);

	always_comb begin
		port_word = `CLP_ZERO32;
		port_word[`CLP_STRAP_BIT] = strap_s;
		port_word[`CLP_HUB_OK_BIT] = hub_ok_s;
		port_word[`CLP_ONLINE_BIT] = online_s;
		port_word[`CLP_ADAPTER_OK_BIT] = adapter_ok_s;
		port_word[`CLP_ONLINE_ENTRY_ENABLE_BIT] = online_entry_enable_r;
		port_word[`CLP_HBSEL_BIT] = hb_sel_r;
		port_word[`CLP_HUB_TYPE_HI:`CLP_HUB_TYPE_LO] = hub_type_r;
		port_word[`CLP_NODE_ID_HI:`CLP_NODE_ID_LO] = node_id_r;
	end

	always_comb begin
		state_nxt = state_r;
		online_entry_enable_nxt = online_entry_enable_r;
		hb_sel_nxt = hb_sel_r;
		hub_type_nxt = hub_type_r;
		node_id_nxt = node_id_r;
		rxb_nxt = rxb_r;
		online_nxt = online_r;
		rdata_nxt = `CLP_ZERO32;
		rd_port_nxt = 1'b0;
		rd_rxb_nxt = 1'b0;
		// Writes touch only the writable fields
		if (reg_wr && addr_is(reg_addr, `CLP_PORT_OFFSET)) begin
			online_entry_enable_nxt = reg_wdata[`CLP_ONLINE_ENTRY_ENABLE_BIT];
			hb_sel_nxt = reg_wdata[`CLP_HBSEL_BIT];
		end
		if (reg_wr && addr_is(reg_addr, `CLP_RXB_OFFSET)) begin
			rxb_nxt = reg_wdata[`CLP_RXB_HI:`CLP_RXB_LO];
		end
		if (reg_rd) begin
			rd_port_nxt = addr_is(reg_addr, `CLP_PORT_OFFSET);
			rd_rxb_nxt = addr_is(reg_addr, `CLP_RXB_OFFSET);
			if (rd_port_nxt) begin
				rdata_nxt = port_word;
			end else if (rd_rxb_nxt) begin
				rdata_nxt[`CLP_RXB_HI:`CLP_RXB_LO] = rxb_r;
			end
		end
		unique case (state_r)
			clp_pkg::ST_OFFLINE: begin
				if (online_entry_enable_r && partner_ok) begin
					state_nxt = clp_pkg::ST_LOAD;
				end
			end
			clp_pkg::ST_LOAD: begin
				if (arb_r) begin
					hub_type_nxt = `CLP_HUB_TYPE_RST;
					node_id_nxt = `CLP_MASTER_NODE_ID;
				end else begin
					hub_type_nxt = hub_type_s;
					node_id_nxt = node_id_s;
				end
				// Enable withdrawn mid-sequence aborts the entry
				if (online_entry_enable_r && partner_ok) begin
					state_nxt = clp_pkg::ST_ONLINE;
					online_nxt = 1'b1;
					online_entry_enable_nxt = 1'b0;
				end else begin
					state_nxt = clp_pkg::ST_OFFLINE;
				end
			end
			clp_pkg::ST_ONLINE: begin
				// Cable pull drops us here; the cleared enable stops re-entry
				if (!partner_ok || hb_expire) begin
					state_nxt = clp_pkg::ST_OFFLINE;
					online_nxt = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= clp_pkg::ST_OFFLINE;
			online_entry_enable_r <= 1'b0;
			hb_sel_r <= 1'b0;
			hub_type_r <= `CLP_HUB_TYPE_RST;
			node_id_r <= `CLP_NODE_ID_RST;
			rxb_r <= `CLP_RXB_RST;
			online_r <= 1'b0;
			arb_r <= 1'b0;
			rdata_r <= `CLP_ZERO32;
			rvalid_r <= 1'b0;
			rd_port_r <= 1'b0;
			rd_rxb_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			online_entry_enable_r <= online_entry_enable_nxt;
			hb_sel_r <= hb_sel_nxt;
			hub_type_r <= hub_type_nxt;
			node_id_r <= node_id_nxt;
			rxb_r <= rxb_nxt;
			online_r <= online_nxt;
			arb_r <= strap_s;
			rdata_r <= rdata_nxt;
			rvalid_r <= reg_rd;
			rd_port_r <= rd_port_nxt;
			rd_rxb_r <= rd_rxb_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	logic [5:0] peer_id_r;

	// Master hands id one to its peer; a hub assigns ids itself
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			peer_id_r <= `CLP_NODE_ID_RST;
		end else begin
			peer_id_r <= strap_s ? `CLP_PEER_NODE_ID : `CLP_NODE_ID_RST;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;
	assign port_online = online_r;
	assign link_arbiter = arb_r;
	assign node_id = node_id_r;
	assign peer_node_id = peer_id_r;
	assign receive_window_base = rxb_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_online_entry_enable_needed;
		$rose(online_r) |-> $past(online_entry_enable_r) && $past(state_r == clp_pkg::ST_LOAD);
	endproperty
	a_online_entry_enable_needed: assert property (p_online_entry_enable_needed) else $error("online without enable");

	property p_online_entry_enable_cleared;
		$rose(online_r) |-> !online_entry_enable_r;
	endproperty
	a_online_entry_enable_cleared: assert property (p_online_entry_enable_cleared) else $error("enable not cleared");

	property p_strap_read;
		rvalid_r && rd_port_r |-> rdata_r[`CLP_STRAP_BIT] == $past(strap_s);
	endproperty
	a_strap_read: assert property (p_strap_read) else $error("strap bit wrong");

	property p_link_bits;
		rvalid_r && rd_port_r |-> rdata_r[`CLP_HUB_OK_BIT:`CLP_ADAPTER_OK_BIT] ==
			$past({hub_ok_s, online_s, adapter_ok_s});
	endproperty
	a_link_bits: assert property (p_link_bits) else $error("link status bits wrong");

	property p_master_ids;
		$rose(online_r) && arb_r |-> node_id_r == `CLP_MASTER_NODE_ID &&
			hub_type_r == `CLP_HUB_TYPE_RST;
	endproperty
	a_master_ids: assert property (p_master_ids) else $error("master ids wrong");

	property p_hub_load;
		state_r == clp_pkg::ST_LOAD && !arb_r ##1 online_r |-> node_id_r == $past(node_id_s, 1);
	endproperty
	a_hub_load: assert property (p_hub_load) else $error("node id not loaded");

	// Select must follow software, it alone decides the period
	property p_hb_limit;
		reg_wr && addr_is(reg_addr, `CLP_PORT_OFFSET) |=>
			hb_sel_r == $past(reg_wdata[`CLP_HBSEL_BIT]);
	endproperty
	a_hb_limit: assert property (p_hb_limit) else $error("heartbeat limit wrong");

	property p_hb_offline;
		hb_expire && online_r |=> !online_r && state_r == clp_pkg::ST_OFFLINE;
	endproperty
	a_hb_offline: assert property (p_hb_offline) else $error("heartbeat did not drop port");

	property p_reserved;
		rvalid_r |-> rdata_r[15:0] == 16'h0000 && rdata_r[25] == 1'b0 &&
			(!rd_rxb_r || rdata_r[26:0] == 27'h0);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

	property p_rxb_write;
		reg_wr && addr_is(reg_addr, `CLP_RXB_OFFSET) |=> rxb_r == $past(reg_wdata[31:27]);
	endproperty
	a_rxb_write: assert property (p_rxb_write) else $error("receive base not written");
endmodule

// file: clp_link_model.sv
// Far end of the link: a hub line card, or a peer adapter in virtual hub mode.
// Assumes the bench picks the role, the slot and whether the cable is in.
`timescale 1ns/10ps
module clp_link_model (
	// Bench control
	input wire logic up,
	input wire logic hub,
	input wire logic [2:0] slot,
	// Link lines
	output logic hub_ok,
	output logic link_online,
	output logic adapter_ok,
	output logic [2:0] hub_type,
	output logic [5:0] node_id
);
	assign hub_ok = up & hub;
	assign link_online = up;
	assign adapter_ok = up;
	// Unplugged lines show junk, not the last id
	assign hub_type = up ? 3'h1 : 3'h6;
	assign node_id = up ? {3'h0, slot} : {3'h7, ~slot};
endmodule

// file: clp_port_regs_test.sv
// Self-checking bench for the link port register bank.
// Assumes the link model at the far side and short heartbeat counts.
`timescale 1ns/10ps
`include "clp_cfg.svh"
module clp_port_regs_test;
	localparam logic [19:0] PORT = `CLP_PORT_OFFSET;
	localparam logic [19:0] RXB = `CLP_RXB_OFFSET;
	logic clk, reset, reg_wr, reg_rd, reg_rvalid, strap, enforce, tx_issued;
	logic up, hub, port_online, link_arbiter, hub_ok, online, adapter_ok;
	logic [19:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [2:0] slot, hub_type;
	logic [5:0] node_in, node_id, peer_node_id;
	logic [4:0] rx_base;
	int bad_count = 0;
	int tests_run = 0;
	clp_port_regs #(.HB_LONG_CYCLES(32'd40), .HB_SHORT_CYCLES(32'd10)) dut (
		.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.virtual_hub_strap(strap), .hub_ok_in(hub_ok), .link_online_in(online),
		.adapter_ok_in(adapter_ok), .hub_type_in(hub_type), .node_id_in(node_in),
		.heartbeat_enforce(enforce), .tx_issued(tx_issued), .port_online(port_online),
		.link_arbiter(link_arbiter), .node_id(node_id), .peer_node_id(peer_node_id),
		.receive_window_base(rx_base));
	clp_link_model far (.up(up), .hub(hub), .slot(slot), .hub_ok(hub_ok),
		.link_online(online), .adapter_ok(adapter_ok), .hub_type(hub_type),
		.node_id(node_in));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input logic [19:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stands one cycle only, so it is sampled just after that edge
	task rd(input logic [19:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("rvalid", 32'(reg_rvalid), 32'h1);
		chk(what, reg_rdata, exp);
	endtask
	task wait_online(input logic v, input int lim);
		for (int i = 0; i < lim && port_online !== v; i++) begin
			@(posedge clk);
			#1;
		end
		chk("port_online", 32'(port_online), 32'(v));
	endtask
	task idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#3_000_000;
		bad_count++;
		end_of_test;
	end
	initial begin
		reset = 1'b1;
		{reg_wr, reg_rd, strap, enforce, tx_issued, up, hub} = '0;
		reg_addr = '0;
		reg_wdata = '0;
		slot = 3'h5;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		rd(PORT, 32'h0000_0000, "port reset");
		rd(RXB, 32'h0000_0000, "rxb reset");
		rd(20'h4_1000, 32'h0000_0000, "unmapped");
		$display("reset values done");
		wr(PORT, 32'hFFFF_FFFF);
		rd(PORT, 32'h0C00_0000, "port ones");
		wr(PORT, 32'h0000_0000);
		wr(RXB, 32'hFFFF_FFFF);
		wr(20'h4_1000, 32'h0000_0000);
		rd(RXB, 32'hF800_0000, "rxb ones");
		chk("rx_base", 32'(rx_base), 32'h1F);
		$display("access kinds done");
		hub <= 1'b1;
		up <= 1'b1;
		idle(8);
		chk("no enable", 32'(port_online), 32'h0);
		wr(PORT, 32'h0C00_0000);
		wait_online(1'b1, 20);
		rd(PORT, {4'h7, 2'b01, 1'b0, 3'h1, 6'd5, 16'h0}, "hub online");
		chk("node_id", 32'(node_id), 32'd5);
		chk("peer id hub", 32'(peer_node_id), 32'(`CLP_NODE_ID_RST));
		up <= 1'b0;
		wait_online(1'b0, 20);
		up <= 1'b1;
		idle(12);
		chk("no reentry", 32'(port_online), 32'h0);
		$display("hub online done");
		enforce <= 1'b1;
		wr(PORT, 32'h0800_0000);
		wait_online(1'b1, 20);
		repeat (6) begin
			idle(5);
			tx_issued <= 1'b1;
			idle(1);
			tx_issued <= 1'b0;
		end
		idle(7);
		chk("kept alive", 32'(port_online), 32'h1);
		wait_online(1'b0, 20);
		wr(PORT, 32'h0C00_0000);
		wait_online(1'b1, 20);
		idle(25);
		chk("long timeout", 32'(port_online), 32'h1);
		wait_online(1'b0, 40);
		enforce <= 1'b0;
		$display("heartbeat done");
		up <= 1'b0;
		hub <= 1'b0;
		strap <= 1'b1;
		idle(3);
		up <= 1'b1;
		idle(6);
		chk("arbiter", 32'(link_arbiter), 32'h1);
		wr(PORT, 32'h0800_0000);
		wait_online(1'b1, 20);
		rd(PORT, 32'hB000_0000, "virtual hub");
		chk("master id", 32'(node_id), 32'(`CLP_MASTER_NODE_ID));
		chk("peer id", 32'(peer_node_id), 32'(`CLP_PEER_NODE_ID));
		$display("virtual hub done");
		end_of_test;
	end
endmodule
